// file: design/sync_pkg.sv
// Purpose: Shared constants and types for spindle sync control
// Assumes: 250 MHz reference clock
// Notes:   Long times are module parameters in the top level
package sync_pkg;

    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned REV_PERIOD_US    = 16667;
    localparam int unsigned LOCK_TOL_US      = 50;
    localparam int unsigned SYNC_LIMIT_S     = 30;
    localparam int unsigned REF_LOSS_REVS    = 3;
    localparam longint unsigned REV_CYCLES   = longint'(REV_PERIOD_US) * CLK_MHZ;
    localparam longint unsigned TOL_CYCLES   = longint'(LOCK_TOL_US) * CLK_MHZ;
    localparam longint unsigned SYNC_CYCLES  = longint'(SYNC_LIMIT_S) * 1000000 * CLK_MHZ;

    localparam logic [7:0] BC_LOAD_FUNC      = 8'h01;
    localparam logic [7:0] FN_ENABLE_MASTER  = 8'h1f;
    localparam logic [7:0] FN_DISABLE_MASTER = 8'h2e;
    localparam int unsigned ST0_BC_EXC_BIT   = 5;
    localparam int unsigned ST2_INV_PAR_BIT  = 6;

    typedef struct packed {
        logic [7:0] bus_ctl;
        logic [7:0] func;
    } bus_cmd_t;

    typedef struct packed {
        logic [7:0] octet0;
        logic [7:0] octet2;
        logic       exception;
    } end_status_t;

    typedef enum logic [1:0] {
        SL_FREE,
        SL_PULL,
        SL_LOCKED
    } slave_state_t;

endpackage : sync_pkg

// file: design/spindle_sync_master_control.sv
// Purpose: Spindle sync master/slave role and index phase lock
// Assumes: Reference and jumper come from pins; commands from same clock
// Notes:   Phase correction is an advance/retard pulse to the motor loop
// Operation
// - Slave locks index to external reference
// - No reference: run free, no error
// - Locked index within 50 us of reference
// - Sync within 30 s after spin-up
// - Sync within 30 s of new reference
// - Jumper sampled at power-up makes master
// - Function 1F makes device master
// - Function 2E ends master role
// - Jumper master rejects enable with exception
// - Jumper master rejects disable, keeps driving
// - Rejection sets octet0 bit5, octet2 bit6
`timescale 1ns/1ps
module spindle_sync_master_control
    import sync_pkg::*;
#(
    parameter longint unsigned REV_CYC  = REV_CYCLES,
    parameter longint unsigned TOL_CYC  = TOL_CYCLES,
    parameter longint unsigned SYNC_CYC = SYNC_CYCLES
)(
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    input  wire logic        i_jumper_pin,
    input  wire logic        i_ref_pin,
    input  wire logic        i_index,
    input  wire logic        i_at_speed,
    input  wire logic        i_cmd_valid,
    input  wire bus_cmd_t    i_cmd,
    output logic             o_ref_drive,
    output logic             o_ref_oe,
    output logic             o_is_master,
    output logic             o_locked,
    output logic             o_phase_adv,
    output logic             o_phase_ret,
    output logic             o_sync_timeout,
    output logic             o_status_valid,
    output end_status_t      o_status
);

    localparam int CW = 40;

    logic [1:0]  jmp_sync_q, ref_sync_q;
    logic        ref_prev_q, idx_prev_q, speed_prev_q;
    logic        sampled_q, jumper_master_q, cmd_master_q;
    logic        sampled_d, jumper_master_d, cmd_master_d;
    logic [1:0]  warm_q, warm_d;
    logic [CW-1:0] ref_age_q, ref_age_d, idx_age_q, idx_age_d;
    logic [CW-1:0] own_cnt_q, own_cnt_d, sync_cnt_q, sync_cnt_d;
    logic        ref_seen_q, ref_seen_d;
    slave_state_t st_q, st_d;
    logic        drive_d, oe_d, master_d, locked_d, adv_d, ret_d, tmo_d, sv_d;
    end_status_t status_d;
    logic        ref_rise, idx_rise, ref_present, restart;

    assign ref_rise    = ref_sync_q[1] & ~ref_prev_q;
    assign idx_rise    = i_index & ~idx_prev_q;
    assign ref_present = ref_seen_q;
    assign restart     = (i_at_speed & ~speed_prev_q) | (ref_rise & ~ref_seen_q);

    always_comb
    begin
        warm_d          = {warm_q[0], 1'b1};
        sampled_d       = sampled_q | warm_q[1];
        jumper_master_d = jumper_master_q;
        cmd_master_d    = cmd_master_q;
        sv_d            = 1'b0;
        status_d        = '0;
        // jumper at power-up, once synchroniser filled
        if (!sampled_q && warm_q[1])
            jumper_master_d = jmp_sync_q[1];
        if (i_cmd_valid && i_cmd.bus_ctl == BC_LOAD_FUNC &&
            (i_cmd.func == FN_ENABLE_MASTER || i_cmd.func == FN_DISABLE_MASTER))
        begin
            sv_d = 1'b1;
            if (jumper_master_q)
            begin
                status_d.exception                 = 1'b1;
                status_d.octet0[ST0_BC_EXC_BIT]    = 1'b1;
                status_d.octet2[ST2_INV_PAR_BIT]   = 1'b1;
            end
            else if (i_cmd.func == FN_ENABLE_MASTER)
                cmd_master_d = 1'b1;
            else
                cmd_master_d = 1'b0;
        end
    end

    always_comb
    begin
        ref_age_d  = (ref_age_q == '1) ? ref_age_q : ref_age_q + 1'b1;
        idx_age_d  = (idx_age_q == '1) ? idx_age_q : idx_age_q + 1'b1;
        own_cnt_d  = own_cnt_q + 1'b1;
        sync_cnt_d = sync_cnt_q;
        ref_seen_d = ref_seen_q;
        st_d       = st_q;
        adv_d      = 1'b0;
        ret_d      = 1'b0;
        tmo_d      = o_sync_timeout;
        master_d   = jumper_master_q | cmd_master_q;
        drive_d    = 1'b0;
        if (ref_rise)
            ref_age_d = '0;
        if (idx_rise)
            idx_age_d = '0;
        if (own_cnt_q >= CW'(REV_CYC - 1))
            own_cnt_d = '0;
        if (master_d)
        begin
            drive_d = (own_cnt_q < CW'(REV_CYC / 2));
            st_d    = SL_FREE;
            tmo_d   = 1'b0;
        end
        else
        begin
            if (ref_rise)
                ref_seen_d = 1'b1;
            else if (ref_age_q > CW'(REV_CYC * REF_LOSS_REVS))
                ref_seen_d = 1'b0;
            if (!ref_present || !i_at_speed)
            begin
                st_d  = SL_FREE;
                tmo_d = 1'b0;
            end
            else
            begin
                if (restart || st_q == SL_FREE)
                begin
                    st_d       = SL_PULL;
                    sync_cnt_d = '0;
                    tmo_d      = 1'b0;
                end
                else if (st_q == SL_PULL && sync_cnt_q < CW'(SYNC_CYC))
                    sync_cnt_d = sync_cnt_q + 1'b1;
                else if (st_q == SL_PULL)
                    tmo_d = 1'b1;
                if (idx_rise)
                begin
                    adv_d = (ref_age_q > CW'(REV_CYC / 2));
                    ret_d = (ref_age_q <= CW'(REV_CYC / 2)) && (ref_age_q != '0);
                    case (st_q)
                        SL_PULL:
                            if (ref_age_q <= CW'(TOL_CYC) || ref_age_q >= CW'(REV_CYC - TOL_CYC))
                                st_d = SL_LOCKED;
                        SL_LOCKED:
                            if (ref_age_q > CW'(TOL_CYC) && ref_age_q < CW'(REV_CYC - TOL_CYC))
                                st_d = SL_PULL;
                        default:
                            st_d = SL_PULL;
                    endcase
                end
            end
        end
        oe_d     = master_d;
        locked_d = (st_d == SL_LOCKED);
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            jmp_sync_q      <= '0;
            ref_sync_q      <= '0;
            ref_prev_q      <= 1'b0;
            idx_prev_q      <= 1'b0;
            speed_prev_q    <= 1'b0;
            sampled_q       <= 1'b0;
            warm_q          <= '0;
            jumper_master_q <= 1'b0;
            cmd_master_q    <= 1'b0;
            ref_age_q       <= '1;
            idx_age_q       <= '1;
            own_cnt_q       <= '0;
            sync_cnt_q      <= '0;
            ref_seen_q      <= 1'b0;
            st_q            <= SL_FREE;
            o_ref_drive     <= 1'b0;
            o_ref_oe        <= 1'b0;
            o_is_master     <= 1'b0;
            o_locked        <= 1'b0;
            o_phase_adv     <= 1'b0;
            o_phase_ret     <= 1'b0;
            o_sync_timeout  <= 1'b0;
            o_status_valid  <= 1'b0;
            o_status        <= '0;
        end
        else if (i_ce)
        begin
            jmp_sync_q      <= {jmp_sync_q[0], i_jumper_pin};
            ref_sync_q      <= {ref_sync_q[0], i_ref_pin};
            ref_prev_q      <= ref_sync_q[1];
            idx_prev_q      <= i_index;
            speed_prev_q    <= i_at_speed;
            sampled_q       <= sampled_d;
            warm_q          <= warm_d;
            jumper_master_q <= jumper_master_d;
            cmd_master_q    <= cmd_master_d;
            ref_age_q       <= ref_age_d;
            idx_age_q       <= idx_age_d;
            own_cnt_q       <= own_cnt_d;
            sync_cnt_q      <= sync_cnt_d;
            ref_seen_q      <= ref_seen_d;
            st_q            <= st_d;
            o_ref_drive     <= drive_d;
            o_ref_oe        <= oe_d;
            o_is_master     <= master_d;
            o_locked        <= locked_d;
            o_phase_adv     <= adv_d;
            o_phase_ret     <= ret_d;
            o_sync_timeout  <= tmo_d;
            o_status_valid  <= sv_d;
            o_status        <= status_d;
        end
    end

endmodule : spindle_sync_master_control

// file: tb/sync_ctl_props.sv
// Purpose: Assertions on master role and ending status
// Assumes: Same clock and reset as the control block
// Notes:   Bound to spindle_sync_master_control
`timescale 1ns/1ps
module sync_ctl_props
    import sync_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic        i_ce,
    input wire logic        i_cmd_valid,
    input wire bus_cmd_t    i_cmd,
    input wire logic        o_ref_oe,
    input wire logic        o_is_master,
    input wire logic        o_status_valid,
    input wire end_status_t o_status
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    logic take_en;
    logic take_dis;
    assign take_en  = i_ce && i_cmd_valid && i_cmd.bus_ctl == BC_LOAD_FUNC && i_cmd.func == FN_ENABLE_MASTER;
    assign take_dis = i_ce && i_cmd_valid && i_cmd.bus_ctl == BC_LOAD_FUNC && i_cmd.func == FN_DISABLE_MASTER;
    a_status_after_cmd: assert property (take_en || take_dis |=> o_status_valid)
        else $error("no ending status after command");
    a_status_has_cause: assert property (o_status_valid |-> $past(i_cmd_valid))
        else $error("ending status without command");
    a_enable_sets_master: assert property (take_en |-> ##2 o_is_master)
        else $error("enable did not make master");
    a_disable_clears: assert property (take_dis ##1 (o_status_valid && !o_status.exception) |=> !o_is_master)
        else $error("disable did not end master");
    a_reject_bits_set: assert property (o_status_valid && o_status.exception |->
        o_status.octet0[ST0_BC_EXC_BIT] && o_status.octet2[ST2_INV_PAR_BIT])
        else $error("exception bits missing");
    a_reject_keeps_role: assert property (o_status_valid && o_status.exception |-> o_is_master [*2])
        else $error("role changed on rejection");
    a_drive_when_master: assert property (o_ref_oe == o_is_master)
        else $error("reference enable differs from role");
    a_role_persists: assert property ($fell(o_is_master) |-> $past(i_cmd_valid, 2))
        else $error("master role lost without command");
endmodule : sync_ctl_props

bind spindle_sync_master_control sync_ctl_props u_props (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_ref_oe(o_ref_oe), .o_is_master(o_is_master),
    .o_status_valid(o_status_valid), .o_status(o_status));

// file: tb/spindle_chain_model.sv
// Purpose: Motor index and chain reference source
// Assumes: One revolution is REV clock cycles
// Notes:   Index trails the reference mark by 5 cycles
`timescale 1ns/1ps
module spindle_chain_model #(
    parameter int unsigned REV = 1000
)(
    input  wire logic  i_ref_clk,
    input  wire logic  i_nrst,
    input  wire logic  i_run,
    output logic       o_ref_pin,
    output logic       o_index,
    output logic       o_at_speed
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    always_comb cnt_d = (cnt_q == 16'(REV - 1)) ? 16'h0000 : cnt_q + 16'h0001;
    always_ff @(posedge i_ref_clk or negedge i_nrst)
        if (!i_nrst) cnt_q <= 16'h0000; else cnt_q <= cnt_d;
    assign o_ref_pin  = i_run && cnt_q < 16'h000a;
    assign o_index    = cnt_q >= 16'h0005 && cnt_q < 16'h000f;
    assign o_at_speed = i_nrst;
endmodule : spindle_chain_model

// file: tb/tb.sv
// Purpose: Role, status and lock scenarios
// Assumes: Short revolution and windows
// Notes:   Reference pin mixes chain source and own drive
`timescale 1ns/1ps
module tb;
    import sync_pkg::*;
    logic        clk, nrst, jumper, run, cmd_valid, ref_src, index, at_speed;
    logic        ref_drive, ref_oe, is_master, locked, status_valid, tmo;
    bus_cmd_t    cmd;
    end_status_t status;
    int          fails, compares, nstat;
    spindle_chain_model #(.REV(1000)) chain (.i_ref_clk(clk), .i_nrst(nrst), .i_run(run),
        .o_ref_pin(ref_src), .o_index(index), .o_at_speed(at_speed));
    spindle_sync_master_control #(.REV_CYC(1000), .TOL_CYC(20), .SYNC_CYC(50000)) dut (.i_ref_clk(clk),
        .i_nrst(nrst), .i_ce(1'b1), .i_jumper_pin(jumper), .i_ref_pin(ref_oe ? ref_drive : ref_src),
        .i_index(index), .i_at_speed(at_speed), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_ref_drive(ref_drive),
        .o_ref_oe(ref_oe), .o_is_master(is_master), .o_locked(locked), .o_phase_adv(), .o_phase_ret(),
        .o_sync_timeout(tmo), .o_status_valid(status_valid), .o_status(status));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (status_valid === 1'b1) nstat++;
    task automatic results();
        $display("fails %0d compares %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic rst(input logic j);
        nrst   <= 1'b0;
        jumper <= j;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
    endtask : rst
    task automatic send(input logic [7:0] bc, input logic [7:0] fn, input logic sv, input logic exc, input logic m);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= '{bus_ctl: bc, func: fn};
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1 check(32'(status_valid), 32'(sv));
        if (sv) check({status.exception, status.octet0[5], status.octet2[6]}, {3{exc}});
        @(posedge clk);
        #1 check(32'(is_master), 32'(m));
        check(32'(ref_oe), 32'(m));
    endtask : send
    task automatic wait_lock();
        int n;
        for (n = 0; n < 52000 && locked !== 1'b1; n++) @(posedge clk);
        if (n == 52000) begin fails++; results(); end
    endtask : wait_lock
    initial
    begin
        {nrst, jumper, run, cmd_valid} = 4'h0;
        cmd = '0;
        rst(1'b0);
        repeat (4000) @(posedge clk);
        check(32'(nstat), 32'h0);
        check(32'(locked), 32'h0);
        send(BC_LOAD_FUNC, FN_ENABLE_MASTER, 1'b1, 1'b0, 1'b1);
        send(BC_LOAD_FUNC, FN_DISABLE_MASTER, 1'b1, 1'b0, 1'b0);
        send(8'h02, FN_ENABLE_MASTER, 1'b0, 1'b0, 1'b0);
        run <= 1'b1;
        wait_lock();
        repeat (3000) @(posedge clk);
        check(32'(locked), 32'h1);
        check(32'(tmo), 32'h0);
        rst(1'b1);
        check(32'(is_master), 32'h1);
        send(BC_LOAD_FUNC, FN_ENABLE_MASTER, 1'b1, 1'b1, 1'b1);
        send(BC_LOAD_FUNC, FN_DISABLE_MASTER, 1'b1, 1'b1, 1'b1);
        results();
    end
endmodule : tb
